// >>> hw/igc_regs.svh
// Purpose: Constants for the general call and master serial port block
// Assumes: Included by bare name
// Notes:   Mode codes select master or slave behaviour
`ifndef IGC_REGS_SVH
`define IGC_REGS_SVH

// -----------------------------------------------------------------
// Mode select codes
// -----------------------------------------------------------------
`define IGC_MODE_SLV7     4'h6
`define IGC_MODE_SLV10    4'h7
`define IGC_MODE_MASTER   4'h8
`define IGC_MODE_SLV7_SP  4'hE
`define IGC_MODE_SLV10_SP 4'hF

// -----------------------------------------------------------------
// Fields, values and counts
// -----------------------------------------------------------------
`define IGC_GC_ADDR       8'h00
`define IGC_TEN_HDR       5'h1E
`define IGC_BAUD_MSB      6
`define IGC_ADDR_BIT      4'h7
`define IGC_LAST_BIT      4'h8
`define IGC_SYNC_IDLE     3'h7
`define IGC_RX_WIDTH      8
`define IGC_RX_DEPTH      16

`endif

// >>> hw/igc_pkg.sv
// Purpose: Types for the general call and master serial port block
// Assumes: Used as igc_pkg::name
// Notes:   State codes left to the tool
package igc_pkg;

  // -----------------------------------------------------------------
  // Master sequencer states
  // -----------------------------------------------------------------
  typedef enum logic [2:0] {
    M_IDLE, M_SWAIT, M_SHOLD, M_TLOW, M_THIGH, M_PLOW, M_PSCLH, M_PSDAH
  } igc_mst_type;

  // -----------------------------------------------------------------
  // Slave receiver states
  // -----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_ACK, S_DATA, S_DACK
  } igc_slv_type;

endpackage

// >>> hw/igc_master.sv
// Purpose: General call recognition and master start, send, stop
// Assumes: Pins are open drain, low drive when enable is low
// Notes:   Received bytes wait in a FIFO; full FIFO means no ack
//
// Contract
// - General call is all zero byte when enabled
// - Match pushes byte on eighth clock fall, interrupt flag on ninth
// - Ten bit general call leaves address flag clear
// - Ten bit normal match sets update address flag
// - Start and stop flags clear on reset, disable
// - Master events set port interrupt flag
// - Early transmit write dropped, collision flag set
// - First byte is address with direction bit
// - Eight bit bytes, acknowledge after each
// - Baud reload from low seven address bits
// - Transmit write starts baud counter, stops after ack
// - Counter counts to zero on Q2, Q4
// - Counter reloads while SCL held low
// - Start waits one period, then drives SDA low
// - Second period ends start, clears start request
// - Low lines or early SCL fall abort start
// - Slave ack stored, interrupt after ninth clock
// - Stop interrupt only after stop completes
// - Requests ignored and writes collide during start
`timescale 1ns/1ns
`include "igc_regs.svh"

// -----------------------------------------------------------------
// Receive FIFO
// -----------------------------------------------------------------
module igc_fifo #(
  parameter int WIDTH = `IGC_RX_WIDTH,
  parameter int DEPTH = `IGC_RX_DEPTH
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  // Fill side
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  // Drain side
  output logic                  out_valid_out,
  output logic      [WIDTH-1:0] out_data_out,
  input  wire logic             out_ready_in
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wr_r;
  logic [AW:0]      rd_r;
  logic             push;
  logic             pop;

  assign in_ready_out  = (wr_r - rd_r) != (AW+1)'(DEPTH);
  assign out_valid_out = wr_r != rd_r;
  assign out_data_out  = mem_r[rd_r[AW-1:0]];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      if (push) begin
        wr_r <= wr_r + (AW+1)'(1);
      end
      if (pop) begin
        rd_r <= rd_r + (AW+1)'(1);
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_r[wr_r[AW-1:0]] <= in_data_in;
    end
  end
endmodule

// -----------------------------------------------------------------
// Top
// -----------------------------------------------------------------
module igc_master (
  // Clock and reset
  input  wire logic       CORE_CLK_IN,
  input  wire logic       RST_N_IN,
  // Bus pins
  input  wire logic       SCL_IN,
  output logic            SCL_OUT,
  output logic            SCL_OE_N_OUT,
  input  wire logic       SDA_IN,
  output logic            SDA_OUT,
  output logic            SDA_OE_N_OUT,
  // Configuration
  input  wire logic       PORT_ENABLE_BIT_IN,
  input  wire logic [3:0] PORT_MODE_SELECT_IN,
  input  wire logic       GENERAL_CALL_ENABLE_IN,
  input  wire logic [7:0] ADDRESS_BAUD_REG_IN,
  // Requests
  input  wire logic       START_REQ_SET_IN,
  input  wire logic       STOP_REQ_SET_IN,
  input  wire logic       TX_WR_IN,
  input  wire logic [7:0] TX_DATA_IN,
  // Flag clears
  input  wire logic       INT_CLR_IN,
  input  wire logic       WRITE_COLLISION_FLAG_CLR_IN,
  input  wire logic       BCOL_CLR_IN,
  input  wire logic       UA_CLR_IN,
  // Receive stream
  output logic            RX_VALID_OUT,
  output logic [7:0]      RX_DATA_OUT,
  input  wire logic       RX_READY_IN,
  // Status
  output logic            START_REQUEST_BIT_OUT,
  output logic            STOP_REQUEST_BIT_OUT,
  output logic            TX_BUFFER_FULL_OUT,
  output logic            ACK_RECEIVED_STATUS_OUT,
  output logic            START_SEEN_OUT,
  output logic            STOP_SEEN_OUT,
  output logic            PORT_INTERRUPT_FLAG_OUT,
  output logic            WRITE_COLLISION_FLAG_OUT,
  output logic            BUS_COLLISION_FLAG_OUT,
  output logic            UPDATE_ADDRESS_FLAG_OUT
);
  // -----------------------------------------------------------------
  // Pin synchronisers
  // -----------------------------------------------------------------
  logic [1:0] pin_raw;
  logic [1:0] pin_s_r;
  logic [1:0] pin_d_r;
  assign pin_raw = {SDA_IN, SCL_IN};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      logic [2:0] sh_r;
      always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_N_IN) begin
          sh_r          <= `IGC_SYNC_IDLE;
          pin_s_r[gi]   <= 1'b1;
          pin_d_r[gi]   <= 1'b1;
        end else begin
          sh_r          <= {sh_r[1:0], pin_raw[gi]};
          pin_d_r[gi]   <= pin_s_r[gi];
          if (sh_r[1] == sh_r[2]) begin
            pin_s_r[gi] <= sh_r[2];
          end
        end
      end
    end
  endgenerate

  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl_s     = pin_s_r[0];
  assign sda_s     = pin_s_r[1];
  assign scl_rise  = scl_s && !pin_d_r[0];
  assign scl_fall  = !scl_s && pin_d_r[0];
  assign start_det = scl_s && pin_d_r[0] && !sda_s && pin_d_r[1];
  assign stop_det  = scl_s && pin_d_r[0] && sda_s && !pin_d_r[1];

  // -----------------------------------------------------------------
  // Mode decode
  // -----------------------------------------------------------------
  logic en_mst;
  logic ten_bit;
  logic en_slv;
  assign en_mst  = PORT_ENABLE_BIT_IN && PORT_MODE_SELECT_IN == `IGC_MODE_MASTER;
  assign ten_bit = PORT_MODE_SELECT_IN == `IGC_MODE_SLV10
                || PORT_MODE_SELECT_IN == `IGC_MODE_SLV10_SP;
  assign en_slv  = PORT_ENABLE_BIT_IN && (ten_bit
                || PORT_MODE_SELECT_IN == `IGC_MODE_SLV7
                || PORT_MODE_SELECT_IN == `IGC_MODE_SLV7_SP);

  // -----------------------------------------------------------------
  // Baud counter
  // -----------------------------------------------------------------
  logic [1:0] phase_r;
  logic [6:0] brg_r;
  logic       brg_ld;
  logic       brg_zero;
  logic       tick;
  assign tick     = phase_r[0];
  assign brg_zero = brg_r == 7'h00;

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      phase_r <= 2'h0;
      brg_r   <= 7'h00;
    end else begin
      phase_r <= phase_r + 2'h1;
      if (brg_ld) begin
        brg_r <= ADDRESS_BAUD_REG_IN[`IGC_BAUD_MSB:0];
      end else if (tick && !brg_zero) begin
        brg_r <= brg_r - 7'h01;
      end
    end
  end

  // -----------------------------------------------------------------
  // Master requests
  // -----------------------------------------------------------------
  igc_pkg::igc_mst_type m_state_r;
  igc_pkg::igc_mst_type m_state_nxt;
  logic       sen_r;
  logic       pen_r;
  logic       bf_r;
  logic [7:0] tx_buf_r;
  logic       m_idle;
  logic       start_ok;
  logic       stop_ok;
  logic       tx_ok;
  logic       tx_bad;
  logic       sen_clr;
  logic       pen_clr;
  logic       bf_clr;
  assign m_idle   = m_state_r == igc_pkg::M_IDLE;
  assign start_ok = en_mst && START_REQ_SET_IN && !sen_r && !pen_r;
  assign stop_ok  = en_mst && STOP_REQ_SET_IN && !sen_r && !pen_r;
  assign tx_ok    = en_mst && TX_WR_IN && m_idle && !sen_r && !pen_r && !bf_r;
  assign tx_bad   = TX_WR_IN && !tx_ok;

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN || !en_mst) begin
      sen_r <= 1'b0;
      pen_r <= 1'b0;
      bf_r  <= 1'b0;
    end else begin
      sen_r <= start_ok || (sen_r && !sen_clr);
      pen_r <= stop_ok || (pen_r && !pen_clr);
      bf_r  <= tx_ok || (bf_r && !bf_clr);
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      tx_buf_r <= 8'h00;
    end else if (tx_ok) begin
      tx_buf_r <= TX_DATA_IN;
    end
  end

  // -----------------------------------------------------------------
  // Master sequencer
  // -----------------------------------------------------------------
  logic [3:0] m_bit_r;
  logic [3:0] m_bit_nxt;
  logic [7:0] m_sr_r;
  logic [7:0] m_sr_nxt;
  logic       mscl_r;
  logic       mscl_nxt;
  logic       msda_r;
  logic       msda_nxt;
  logic       ack_r;
  logic       ack_nxt;
  logic       m_int;
  logic       m_bcol;

  always_comb begin
    m_state_nxt = m_state_r;
    m_bit_nxt   = m_bit_r;
    m_sr_nxt    = m_sr_r;
    mscl_nxt    = mscl_r;
    msda_nxt    = msda_r;
    ack_nxt     = ack_r;
    brg_ld      = 1'b0;
    m_int       = 1'b0;
    m_bcol      = 1'b0;
    sen_clr     = 1'b0;
    pen_clr     = 1'b0;
    bf_clr      = 1'b0;
    unique case (m_state_r)
      igc_pkg::M_IDLE: begin
        if (sen_r) begin
          if (scl_s && sda_s) begin
            brg_ld      = 1'b1;
            m_state_nxt = igc_pkg::M_SWAIT;
          end else begin
            m_bcol  = 1'b1;
            sen_clr = 1'b1;
          end
        end else if (pen_r) begin
          mscl_nxt    = 1'b1;
          msda_nxt    = 1'b1;
          brg_ld      = 1'b1;
          m_state_nxt = igc_pkg::M_PLOW;
        end else if (bf_r) begin
          m_sr_nxt    = tx_buf_r;
          m_bit_nxt   = 4'h0;
          mscl_nxt    = 1'b1;
          brg_ld      = 1'b1;
          m_state_nxt = igc_pkg::M_TLOW;
        end
      end
      igc_pkg::M_SWAIT: begin
        if (!scl_s || (brg_zero && !sda_s)) begin
          m_bcol      = 1'b1;
          sen_clr     = 1'b1;
          m_state_nxt = igc_pkg::M_IDLE;
        end else if (brg_zero) begin
          msda_nxt    = 1'b1;
          brg_ld      = 1'b1;
          m_state_nxt = igc_pkg::M_SHOLD;
        end
      end
      igc_pkg::M_SHOLD: begin
        if (brg_zero) begin
          sen_clr     = 1'b1;
          m_int       = 1'b1;
          m_state_nxt = igc_pkg::M_IDLE;
        end
      end
      igc_pkg::M_TLOW: begin
        msda_nxt = (m_bit_r == `IGC_LAST_BIT) ? 1'b0 : !m_sr_r[7];
        if (brg_zero) begin
          mscl_nxt    = 1'b0;
          brg_ld      = 1'b1;
          m_state_nxt = igc_pkg::M_THIGH;
        end
      end
      igc_pkg::M_THIGH: begin
        if (!scl_s) begin
          brg_ld = 1'b1;
        end else if (brg_zero) begin
          mscl_nxt = 1'b1;
          if (m_bit_r == `IGC_LAST_BIT) begin
            ack_nxt     = sda_s;
            m_int       = 1'b1;
            m_state_nxt = igc_pkg::M_IDLE;
          end else begin
            bf_clr      = m_bit_r == `IGC_ADDR_BIT;
            m_sr_nxt    = {m_sr_r[6:0], 1'b0};
            m_bit_nxt   = m_bit_r + 4'h1;
            brg_ld      = 1'b1;
            m_state_nxt = igc_pkg::M_TLOW;
          end
        end
      end
      igc_pkg::M_PLOW: begin
        if (brg_zero) begin
          mscl_nxt    = 1'b0;
          brg_ld      = 1'b1;
          m_state_nxt = igc_pkg::M_PSCLH;
        end
      end
      igc_pkg::M_PSCLH: begin
        if (!scl_s) begin
          brg_ld = 1'b1;
        end else if (brg_zero) begin
          msda_nxt    = 1'b0;
          brg_ld      = 1'b1;
          m_state_nxt = igc_pkg::M_PSDAH;
        end
      end
      igc_pkg::M_PSDAH: begin
        if (brg_zero) begin
          pen_clr     = 1'b1;
          m_int       = 1'b1;
          m_state_nxt = igc_pkg::M_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN || !en_mst) begin
      m_state_r <= igc_pkg::M_IDLE;
      m_bit_r   <= 4'h0;
      m_sr_r    <= 8'h00;
      mscl_r    <= 1'b0;
      msda_r    <= 1'b0;
    end else begin
      m_state_r <= m_state_nxt;
      m_bit_r   <= m_bit_nxt;
      m_sr_r    <= m_sr_nxt;
      mscl_r    <= mscl_nxt;
      msda_r    <= msda_nxt;
    end
  end

  // -----------------------------------------------------------------
  // Slave receiver with general call
  // -----------------------------------------------------------------
  igc_pkg::igc_slv_type s_state_r;
  logic [7:0] s_sr_r;
  logic [3:0] s_cnt_r;
  logic       s_ack_r;
  logic       s_push_r;
  logic [7:0] s_push_d_r;
  logic       s_int;
  logic       rx_ready;
  logic       gc_hit;
  logic       ten_hit;
  logic       own_hit;
  logic       addr_hit;
  logic       ua_set;
  logic       byte_end;
  assign byte_end = scl_fall && s_cnt_r == `IGC_LAST_BIT;
  assign gc_hit   = GENERAL_CALL_ENABLE_IN && s_sr_r == `IGC_GC_ADDR;
  assign ten_hit  = s_sr_r[7:3] == `IGC_TEN_HDR
                 && s_sr_r[2:1] == ADDRESS_BAUD_REG_IN[2:1] && !s_sr_r[0];
  assign own_hit  = ten_bit ? ten_hit : s_sr_r[7:1] == ADDRESS_BAUD_REG_IN[7:1]
                 && !s_sr_r[0];
  assign addr_hit = (gc_hit || own_hit) && rx_ready;
  assign ua_set   = s_state_r == igc_pkg::S_ADDR && byte_end
                 && addr_hit && ten_bit && !gc_hit;
  assign s_int    = scl_fall && (s_state_r == igc_pkg::S_ACK
                 || s_state_r == igc_pkg::S_DACK);

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN || !en_slv || stop_det) begin
      s_state_r <= igc_pkg::S_IDLE;
      s_cnt_r   <= 4'h0;
      s_ack_r   <= 1'b0;
    end else if (start_det) begin
      s_state_r <= igc_pkg::S_ADDR;
      s_cnt_r   <= 4'h0;
      s_ack_r   <= 1'b0;
    end else begin
      unique case (s_state_r)
        igc_pkg::S_IDLE: begin
        end
        igc_pkg::S_ADDR, igc_pkg::S_DATA: begin
          if (scl_rise) begin
            s_cnt_r <= s_cnt_r + 4'h1;
          end
          if (byte_end) begin
            s_ack_r   <= s_state_r == igc_pkg::S_ADDR ? addr_hit : rx_ready;
            s_state_r <= s_state_r == igc_pkg::S_ADDR
                       ? (addr_hit ? igc_pkg::S_ACK : igc_pkg::S_IDLE)
                       : (rx_ready ? igc_pkg::S_DACK : igc_pkg::S_IDLE);
          end
        end
        igc_pkg::S_ACK, igc_pkg::S_DACK: begin
          if (scl_fall) begin
            s_ack_r   <= 1'b0;
            s_cnt_r   <= 4'h0;
            s_state_r <= igc_pkg::S_DATA;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      s_sr_r     <= 8'h00;
      s_push_r   <= 1'b0;
      s_push_d_r <= 8'h00;
    end else begin
      if (scl_rise) begin
        s_sr_r <= {s_sr_r[6:0], sda_s};
      end
      s_push_r <= en_slv && byte_end && (s_state_r == igc_pkg::S_DATA
               ? rx_ready : s_state_r == igc_pkg::S_ADDR && addr_hit);
      if (byte_end) begin
        s_push_d_r <= s_sr_r;
      end
    end
  end

  igc_fifo #(
    .WIDTH (`IGC_RX_WIDTH),
    .DEPTH (`IGC_RX_DEPTH)
  ) igc_fifo_inst (
    .clk_in        (CORE_CLK_IN),
    .rst_n_in      (RST_N_IN),
    .in_valid_in   (s_push_r),
    .in_data_in    (s_push_d_r),
    .in_ready_out  (rx_ready),
    .out_valid_out (RX_VALID_OUT),
    .out_data_out  (RX_DATA_OUT),
    .out_ready_in  (RX_READY_IN)
  );

  // -----------------------------------------------------------------
  // Sticky flags
  // -----------------------------------------------------------------
  logic s_seen_r;
  logic p_seen_r;
  logic int_r;
  logic write_collision_flag_r;
  logic bcol_r;
  logic ua_r;

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN || !PORT_ENABLE_BIT_IN) begin
      s_seen_r <= 1'b0;
      p_seen_r <= 1'b0;
      int_r    <= 1'b0;
      write_collision_flag_r   <= 1'b0;
      bcol_r   <= 1'b0;
      ua_r     <= 1'b0;
    end else begin
      s_seen_r <= start_det || (s_seen_r && !stop_det);
      p_seen_r <= stop_det || (p_seen_r && !start_det);
      int_r    <= m_int || s_int || (int_r && !INT_CLR_IN);
      write_collision_flag_r   <= tx_bad || (write_collision_flag_r && !WRITE_COLLISION_FLAG_CLR_IN);
      bcol_r   <= m_bcol || (bcol_r && !BCOL_CLR_IN);
      ua_r     <= ua_set || (ua_r && !UA_CLR_IN);
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= ack_nxt;
    end
  end

  // -----------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------
  assign SCL_OUT                  = 1'b0;
  assign SCL_OE_N_OUT             = !mscl_r;
  assign SDA_OUT                  = 1'b0;
  assign SDA_OE_N_OUT             = !(msda_r || s_ack_r);
  assign START_REQUEST_BIT_OUT    = sen_r;
  assign STOP_REQUEST_BIT_OUT     = pen_r;
  assign TX_BUFFER_FULL_OUT       = bf_r;
  assign ACK_RECEIVED_STATUS_OUT  = ack_r;
  assign START_SEEN_OUT           = s_seen_r;
  assign STOP_SEEN_OUT            = p_seen_r;
  assign PORT_INTERRUPT_FLAG_OUT  = int_r;
  assign WRITE_COLLISION_FLAG_OUT = write_collision_flag_r;
  assign BUS_COLLISION_FLAG_OUT   = bcol_r;
  assign UPDATE_ADDRESS_FLAG_OUT  = ua_r;
endmodule

// >>> dv/igc_master_chk.sv
// Purpose: Checker for the general call and master serial port block
// Assumes: Bound to igc_master, baud reload of 4 or more
// Notes:   Watches top ports only
`timescale 1ns/1ns
module igc_master_chk (
  // Clock and reset
  input wire logic       CORE_CLK_IN,
  input wire logic       RST_N_IN,
  // Inputs
  input wire logic       PORT_ENABLE_BIT_IN,
  input wire logic [7:0] ADDRESS_BAUD_REG_IN,
  input wire logic       TX_WR_IN,
  // Outputs
  input wire logic       SCL_OE_N_OUT,
  input wire logic       SDA_OE_N_OUT,
  input wire logic       START_REQUEST_BIT_OUT,
  input wire logic       STOP_REQUEST_BIT_OUT,
  input wire logic       TX_BUFFER_FULL_OUT,
  input wire logic       ACK_RECEIVED_STATUS_OUT,
  input wire logic       START_SEEN_OUT,
  input wire logic       STOP_SEEN_OUT,
  input wire logic       PORT_INTERRUPT_FLAG_OUT,
  input wire logic       WRITE_COLLISION_FLAG_OUT,
  input wire logic       BUS_COLLISION_FLAG_OUT
);
  default clocking cb @(posedge CORE_CLK_IN);
  endclocking
  default disable iff (!RST_N_IN);
  // ----
  // Properties
  // ----
  a_off_clears: assert property (
    !PORT_ENABLE_BIT_IN |=> !START_SEEN_OUT && !STOP_SEEN_OUT)
    else $error("bus flags kept while disabled");
  a_write_collision_flag_early: assert property (
    TX_WR_IN && START_REQUEST_BIT_OUT && PORT_ENABLE_BIT_IN |=> WRITE_COLLISION_FLAG_OUT)
    else $error("early write not flagged");
  a_start_wait: assert property (
    $rose(START_REQUEST_BIT_OUT) && ADDRESS_BAUD_REG_IN[6:0] >= 7'h04 |-> SDA_OE_N_OUT [*8])
    else $error("data pulled before one baud period");
  a_start_end: assert property (
    $fell(START_REQUEST_BIT_OUT) && $past(RST_N_IN) && $past(PORT_ENABLE_BIT_IN)
    && !BUS_COLLISION_FLAG_OUT |-> PORT_INTERRUPT_FLAG_OUT && !SDA_OE_N_OUT)
    else $error("start end without flag or data low");
  a_stop_done: assert property (
    $fell(STOP_REQUEST_BIT_OUT) && $past(RST_N_IN) && $past(PORT_ENABLE_BIT_IN)
    |-> PORT_INTERRUPT_FLAG_OUT && SDA_OE_N_OUT && SCL_OE_N_OUT)
    else $error("stop end with lines held or no flag");
  a_bcol_abort: assert property (
    $rose(BUS_COLLISION_FLAG_OUT)
    |-> ##[0:2] (!START_REQUEST_BIT_OUT && SDA_OE_N_OUT && SCL_OE_N_OUT))
    else $error("collision did not abort start");
  a_tx_clock: assert property (
    $rose(TX_BUFFER_FULL_OUT) |-> ##[0:2] !SCL_OE_N_OUT)
    else $error("write did not start the clock");
  a_ack_update: assert property (
    $changed(ACK_RECEIVED_STATUS_OUT) && $past(RST_N_IN) && $past(PORT_ENABLE_BIT_IN)
    |-> PORT_INTERRUPT_FLAG_OUT)
    else $error("ack status moved without flag");
endmodule

bind igc_master igc_master_chk igc_master_chk_inst (
  .CORE_CLK_IN(CORE_CLK_IN), .RST_N_IN(RST_N_IN), .PORT_ENABLE_BIT_IN(PORT_ENABLE_BIT_IN),
  .ADDRESS_BAUD_REG_IN(ADDRESS_BAUD_REG_IN), .TX_WR_IN(TX_WR_IN),
  .SCL_OE_N_OUT(SCL_OE_N_OUT), .SDA_OE_N_OUT(SDA_OE_N_OUT),
  .START_REQUEST_BIT_OUT(START_REQUEST_BIT_OUT), .STOP_REQUEST_BIT_OUT(STOP_REQUEST_BIT_OUT),
  .TX_BUFFER_FULL_OUT(TX_BUFFER_FULL_OUT), .ACK_RECEIVED_STATUS_OUT(ACK_RECEIVED_STATUS_OUT),
  .START_SEEN_OUT(START_SEEN_OUT), .STOP_SEEN_OUT(STOP_SEEN_OUT),
  .PORT_INTERRUPT_FLAG_OUT(PORT_INTERRUPT_FLAG_OUT),
  .WRITE_COLLISION_FLAG_OUT(WRITE_COLLISION_FLAG_OUT),
  .BUS_COLLISION_FLAG_OUT(BUS_COLLISION_FLAG_OUT)
);

// >>> dv/igc_slave_model.sv
// Purpose: Bus slave that takes bytes and acks them
// Assumes: Open drain pulls, pull-ups on both lines
// Notes:   Optional clock stretch after each falling clock
`timescale 1ns/1ns
module igc_slave_model (
  // Clock
  input  wire logic clk_in,
  // Bus
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      scl_pull_out,
  output logic      sda_pull_out,
  // Behaviour
  input  wire logic en_in,
  input  wire logic nack_in,
  input  wire logic stretch_in,
  output logic [7:0] byte_out
);
  logic       scl_d = 1'b1;
  logic       sda_d = 1'b1;
  logic [3:0] bit_cnt = 4'h0;
  logic [3:0] hold = 4'h0;
  initial sda_pull_out = 1'b0;
  initial byte_out = 8'h00;
  assign scl_pull_out = hold != 4'h0;
  always @(posedge clk_in) begin
    scl_d <= scl_in;
    sda_d <= sda_in;
    if (hold != 4'h0) hold <= hold - 4'h1;
    if (scl_d && scl_in && sda_d && !sda_in) bit_cnt <= 4'h0;
    if (!scl_d && scl_in && bit_cnt < 4'h9) begin
      bit_cnt <= bit_cnt + 4'h1;
      if (bit_cnt < 4'h8) byte_out <= {byte_out[6:0], sda_in};
    end
    if (scl_d && !scl_in) begin
      if (stretch_in) hold <= 4'hF;
      sda_pull_out <= en_in && !nack_in && bit_cnt == 4'h8;
      if (bit_cnt == 4'h9) bit_cnt <= 4'h0;
    end
  end
endmodule

// >>> dv/tb_igc_master.sv
// Purpose: Testbench for the general call and master serial port block
// Assumes: Pull-ups on both bus lines, baud reload of 4
// Notes:   Bench drives inputs on falling clock
`timescale 1ns/1ns
module tb_igc_master;
  logic clk = 1'b0, rst_n = 1'b0, en = 1'b0, gce = 1'b0, st = 1'b0, sp = 1'b0;
  logic wr = 1'b0, iclr = 1'b0, wclr = 1'b0, bclr = 1'b0, rdy = 1'b0;
  logic t_scl = 1'b0, t_sda = 1'b0, p_en = 1'b1, p_nack = 1'b0, p_str = 1'b0;
  logic [3:0] mode = 4'h8;
  logic [7:0] txd = 8'h00;
  int errors = 0, tests_run = 0;
  wire scl_oe_n, sda_oe_n, p_scl, p_sda, rxv, sreq, preq, bfull, ackst;
  wire sseen, pseen, pint, write_collision_flag, bcol, ua;
  wire [7:0] rxd, p_byte;
  wire scl = !(!scl_oe_n || p_scl || t_scl);
  wire sda = !(!sda_oe_n || p_sda || t_sda);
  always #5 clk = ~clk;
  igc_master igc_master_inst (
    .CORE_CLK_IN(clk), .RST_N_IN(rst_n), .SCL_IN(scl), .SCL_OUT(), .SCL_OE_N_OUT(scl_oe_n),
    .SDA_IN(sda), .SDA_OUT(), .SDA_OE_N_OUT(sda_oe_n), .PORT_ENABLE_BIT_IN(en),
    .PORT_MODE_SELECT_IN(mode), .GENERAL_CALL_ENABLE_IN(gce), .ADDRESS_BAUD_REG_IN(8'h04),
    .START_REQ_SET_IN(st), .STOP_REQ_SET_IN(sp), .TX_WR_IN(wr), .TX_DATA_IN(txd),
    .INT_CLR_IN(iclr), .WRITE_COLLISION_FLAG_CLR_IN(wclr), .BCOL_CLR_IN(bclr), .UA_CLR_IN(iclr),
    .RX_VALID_OUT(rxv), .RX_DATA_OUT(rxd), .RX_READY_IN(rdy), .START_REQUEST_BIT_OUT(sreq),
    .STOP_REQUEST_BIT_OUT(preq), .TX_BUFFER_FULL_OUT(bfull), .ACK_RECEIVED_STATUS_OUT(ackst),
    .START_SEEN_OUT(sseen), .STOP_SEEN_OUT(pseen), .PORT_INTERRUPT_FLAG_OUT(pint),
    .WRITE_COLLISION_FLAG_OUT(write_collision_flag), .BUS_COLLISION_FLAG_OUT(bcol),
    .UPDATE_ADDRESS_FLAG_OUT(ua));
  igc_slave_model igc_slave_model_inst (
    .clk_in(clk), .scl_in(scl), .sda_in(sda), .scl_pull_out(p_scl), .sda_pull_out(p_sda),
    .en_in(p_en), .nack_in(p_nack), .stretch_in(p_str), .byte_out(p_byte));
  // ----
  // Helpers
  // ----
  task check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("Error %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task wait_req();
    for (int k = 0; k < 3000 && (sreq !== 1'b0 || preq !== 1'b0 || pint !== 1'b1); k++) tick(1);
  endtask
  task clr_int();
    iclr = 1'b1;
    tick(1);
    iclr = 1'b0;
  endtask
  task bb_byte(input logic [7:0] d, output logic a);
    for (int i = 7; i >= 0; i--) begin
      t_sda = !d[i];
      tick(10);
      t_scl = 1'b0;
      tick(20);
      t_scl = 1'b1;
      tick(10);
    end
    t_sda = 1'b0;
    tick(10);
    t_scl = 1'b0;
    tick(10);
    a = sda;
    tick(10);
    t_scl = 1'b1;
    tick(8);
  endtask
  // ----
  // Scenarios
  // ----
  task s_start();
    st = 1'b1;
    tick(1);
    st = 1'b0;
    wr = 1'b1;
    txd = 8'h55;
    tick(1);
    wr = 1'b0;
    sp = 1'b1;
    tick(1);
    sp = 1'b0;
    check(write_collision_flag, 1'b1);
    check(preq, 1'b0);
    wait_req();
    check({pint, sreq, sseen, sda}, 4'hA);
    clr_int();
    wclr = 1'b1;
    tick(1);
    wclr = 1'b0;
  endtask
  task s_byte(input logic [7:0] d, input logic nk);
    p_nack = nk;
    p_str = nk;
    wr = 1'b1;
    txd = d;
    tick(1);
    wr = 1'b0;
    check(bfull, 1'b1);
    wait_req();
    check(p_byte, d);
    check({ackst, scl_oe_n, pint}, {nk, 2'b01});
    clr_int();
  endtask
  task s_stop();
    sp = 1'b1;
    tick(1);
    sp = 1'b0;
    wait_req();
    check({pint, scl, sda}, 3'h7);
    tick(8);
    check(pseen, 1'b1);
    clr_int();
  endtask
  task s_bcol();
    t_sda = 1'b1;
    tick(6);
    st = 1'b1;
    tick(1);
    st = 1'b0;
    tick(8);
    check({bcol, sreq, sda_oe_n}, 3'h5);
    t_sda = 1'b0;
    bclr = 1'b1;
    tick(1);
    bclr = 1'b0;
    check(bcol, 1'b0);
  endtask
  task s_gcall(input logic [3:0] m, input logic g, input logic [7:0] b, input logic hit,
               input logic u);
    logic a;
    mode = m;
    gce = g;
    p_en = 1'b0;
    tick(4);
    t_sda = 1'b1;
    tick(20);
    t_scl = 1'b1;
    tick(10);
    bb_byte(b, a);
    check(a, !hit);
    check({pint, rxv, ua}, {hit, hit, u});
    check(hit ? rxd : {7'h00, rxv}, hit ? b : 8'h00);
    t_sda = 1'b1;
    tick(10);
    t_scl = 1'b0;
    tick(20);
    t_sda = 1'b0;
    tick(20);
    rdy = 1'b1;
    clr_int();
    rdy = 1'b0;
    check({ua, pint, rxv}, 3'h0);
  endtask
  // ----
  // Main and verdict
  // ----
  task print_verdict();
    if (errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    tick(5);
    rst_n = 1'b1;
    en = 1'b1;
    tick(2);
    check({sseen, pseen, pint, bcol}, 4'h0);
    s_start();
    s_byte(8'hA4, 1'b0);
    s_byte(8'h3C, 1'b1);
    s_stop();
    s_bcol();
    s_gcall(4'h7, 1'b0, 8'h00, 1'b0, 1'b0);
    s_gcall(4'h7, 1'b1, 8'h00, 1'b1, 1'b0);
    s_gcall(4'h7, 1'b0, 8'hF4, 1'b1, 1'b1);
    s_gcall(4'h6, 1'b1, 8'h04, 1'b1, 1'b0);
    en = 1'b0;
    tick(2);
    check({sseen, pseen}, 2'b00);
    print_verdict();
  end
  initial begin
    #300000;
    errors++;
    print_verdict();
  end
endmodule
